// ==== verilog/ssp_defs.vh ====
// Register offsets, field positions, reset values and character lengths for the serial port
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

// Register indices on the plain register port
`define SSP_ADDR_W        3
`define SSP_REG_RX_CTRL   3'h0
`define SSP_REG_RX_DATA   3'h1
`define SSP_REG_TX_CTRL   3'h2
`define SSP_REG_RATE_CTRL 3'h3
`define SSP_REG_DIV_HI    3'h4
`define SSP_REG_DIV_LO    3'h5
`define SSP_REG_TX_HOLD   3'h6
`define SSP_REG_IRQ_CTRL  3'h7

// receive_status_control fields
`define SSP_RC_PORT_EN    7
`define SSP_RC_NINE_BIT   6
`define SSP_RC_SINGLE     5
`define SSP_RC_CONT       4
`define SSP_RC_OVERRUN    1
`define SSP_RC_NINTH      0

// transmit_status_control fields
`define SSP_TC_CLK_MASTER 7
`define SSP_TC_NINE_BIT   6
`define SSP_TC_TX_EN      5
`define SSP_TC_SYNC       4
`define SSP_TC_SHIFT_IDLE 1
`define SSP_TC_NINTH      0

// Interrupt control fields (flags and enables)
`define SSP_IC_RX_AVAIL   0
`define SSP_IC_TX_EMPTY   1
`define SSP_IC_RX_IE      2
`define SSP_IC_TX_IE      3
`define SSP_IC_PERIPH_IE  4
`define SSP_IC_GLOBAL_IE  5
`define SSP_IC_SLEEP      6

// Reset values
`define SSP_RST_BYTE      8'h00
`define SSP_RST_IRQ_CTRL  8'h02

// Character lengths
`define SSP_BITS_EIGHT    4'h8
`define SSP_BITS_NINE     4'h9

`endif

// ==== verilog/ssp_edge_sync.v ====
// Two-stage synchroniser with edge detection for the external serial clock
`timescale 1ns/1ps
module ssp_edge_sync (
   // Clock, reset, enable
   input  wire ref_clk,
   input  wire rst,
   input  wire clk_en,
   // Asynchronous input
   input  wire async_in,
   // Synchronised level and edges
   output reg  level_q,
   output wire rise,
   output wire fall
);
   reg meta_q;
   reg sync_q;

   // Two flip-flops, then a third for edge history
   always @(posedge ref_clk) begin
      if (rst) begin
         meta_q  <= 1'b0;
         sync_q  <= 1'b0;
         level_q <= 1'b0;
      end else if (clk_en) begin
         meta_q  <= async_in;
         sync_q  <= meta_q;
         level_q <= sync_q;
      end
   end

   // Edges seen from the synchronised stage only
   assign rise = clk_en & sync_q & ~level_q;
   assign fall = clk_en & ~sync_q & level_q;
endmodule

// ==== verilog/ssp_sync_slave.v ====
// Synchronous slave serial port: receive buffer, overrun, nine-bit data, slave transmit
// Operation
// - Slave mode takes its serial clock as an input on the clock pin.
// - Data changes on the leading clock edge and is sampled on the trailing.
// - One data bit moves per serial clock cycle.
// - Buffer holds two characters; a complete third sets the overrun flag.
// - On overrun the buffered characters stay intact and readable.
// - While overrun is set no further characters are accepted.
// - Overrun with single receive clears on a receive data read or when port enable clears.
// - Overrun with continuous receive clears when it or port enable clears.
// - Nine-bit receive shifts nine bits per character.
// - Ninth-bit status shows the ninth bit of the oldest unread character.
// - Receive-available sets on character completion; interrupt if enabled.
// - Clocked mode with clock source clear is a synchronous slave.
// - Both receive enables clear means transmit, else receive.
// - Port enable turns the port on; clearing it disables and resets it.
// - In sleep a second held character loads after the first; then empty sets.
// - Transmit empty with peripheral and transmit enables wakes; global vectors.
// - Single receive clears itself after one complete character.
// - Clearing continuous receive mid-character discards the partial character.
// - Receive-available stays set while unread characters remain.
`timescale 1ns/1ps
`include "ssp_defs.vh"
module ssp_sync_slave (
   // Clock, reset, enable
   input  wire                   ref_clk,
   input  wire                   rst,
   input  wire                   clk_en,
   // Register port
   input  wire [`SSP_ADDR_W-1:0] reg_addr,
   input  wire [7:0]             reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [7:0]             reg_rdata,
   // Serial clock pin
   input  wire                   serial_clock_pin_in,
   output reg                    serial_clock_pin_out,
   output reg                    serial_clock_pin_oe_n,
   // Serial data pin
   input  wire                   serial_data_pin_in,
   output reg                    serial_data_pin_out,
   output reg                    serial_data_pin_oe_n,
   // Events to the core
   output reg                    irq_q,
   output reg                    wake_q
);
   // Control registers
   reg        port_enable_q, nine_rx_q, single_rx_q, cont_rx_q;
   reg        clk_master_q, nine_tx_q, tx_enable_q, sync_mode_q, tx_ninth_q;
   reg [7:0]  rate_ctrl_q, div_hi_q, div_lo_q;
   reg        rx_ie_q, tx_ie_q, periph_ie_q, global_ie_q, sleep_q;
   // Receive path
   reg [8:0]  rx_shift_q;
   reg [3:0]  rx_cnt_q;
   reg [8:0]  rx_buf_q [0:1];
   reg        rx_head_q;
   reg [1:0]  rx_level_q;
   reg        overrun_q;
   reg        overrun_cont_q;
   reg        data_smp_q;
   // Transmit path
   reg [8:0]  tx_hold_q;
   reg        tx_hold_full_q;
   reg [8:0]  tx_shift_q;
   reg [3:0]  tx_cnt_q;
   reg        tx_busy_q;
   reg        data_meta_q, data_sync_q;

   wire       sck_level;
   wire       sck_rise;
   wire       sck_fall;

   // External clock synchroniser and edge finder
   ssp_edge_sync u_sck_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .async_in (serial_clock_pin_in),
      .level_q  (sck_level),
      .rise     (sck_rise),
      .fall     (sck_fall)
   );

   // Character length from the nine-bit select
   function [3:0] char_bits;
      input nine;
      begin
         char_bits = nine ? `SSP_BITS_NINE : `SSP_BITS_EIGHT;
      end
   endfunction

   // Polarity bit of rate_and_polarity_control idles the clock high
   wire clk_idle_hi = rate_ctrl_q[4];
   wire data_inv    = rate_ctrl_q[5];
   wire lead_edge   = clk_idle_hi ? sck_fall : sck_rise;
   wire trail_edge  = clk_idle_hi ? sck_rise : sck_fall;

   wire slave_mode  = port_enable_q & sync_mode_q & ~clk_master_q;
   wire rx_mode     = single_rx_q | cont_rx_q;
   wire rx_active   = slave_mode & rx_mode & ~overrun_q;
   wire tx_active   = slave_mode & ~rx_mode & tx_enable_q;

   wire rd_data     = reg_rd & (reg_addr == `SSP_REG_RX_DATA);
   wire wr_rx_ctrl  = reg_wr & (reg_addr == `SSP_REG_RX_CTRL);
   wire wr_tx_hold  = reg_wr & (reg_addr == `SSP_REG_TX_HOLD);
   wire new_cont    = wr_rx_ctrl ? reg_wdata[`SSP_RC_CONT] : cont_rx_q;
   wire new_enable  = wr_rx_ctrl ? reg_wdata[`SSP_RC_PORT_EN] : port_enable_q;

   // A character completes on the trailing edge of its last bit
   wire rx_sample   = rx_active & trail_edge;
   wire rx_last     = rx_sample & (rx_cnt_q == char_bits(nine_rx_q) - 4'h1);
   wire [8:0] rx_word = nine_rx_q ? {data_sync_q ^ data_inv, rx_shift_q[8:1]}
                                  : {1'b0, data_sync_q ^ data_inv, rx_shift_q[8:2]};
   wire buf_pop     = rd_data & (rx_level_q != 2'd0);
   wire buf_push    = rx_last & ((rx_level_q != 2'd2) | buf_pop);
   wire buf_ovf     = rx_last & (rx_level_q == 2'd2) & ~buf_pop;
   wire tx_done     = tx_active & trail_edge & tx_busy_q
                      & (tx_cnt_q == char_bits(nine_tx_q) - 4'h1);
   wire tx_empty    = ~tx_hold_full_q;

   // Data pin synchroniser
   // Two stages keep a metastable pin away from the shifters
   always @(posedge ref_clk) begin
      if (rst) begin
         data_meta_q <= 1'b0;
         data_sync_q <= 1'b0;
      end else if (clk_en) begin
         data_meta_q <= serial_data_pin_in;
         data_sync_q <= data_meta_q;
      end
   end

   // Control register writes and self-clearing single receive
   always @(posedge ref_clk) begin
      if (rst) begin
         {port_enable_q, nine_rx_q, single_rx_q, cont_rx_q} <= 4'h0;
         {clk_master_q, nine_tx_q, tx_enable_q, sync_mode_q, tx_ninth_q} <= 5'h00;
         rate_ctrl_q <= `SSP_RST_BYTE;
         div_hi_q    <= `SSP_RST_BYTE;
         div_lo_q    <= `SSP_RST_BYTE;
         {rx_ie_q, tx_ie_q, periph_ie_q, global_ie_q, sleep_q} <= 5'h00;
      end else if (clk_en) begin
         if (wr_rx_ctrl) begin
            port_enable_q <= reg_wdata[`SSP_RC_PORT_EN];
            nine_rx_q     <= reg_wdata[`SSP_RC_NINE_BIT];
            single_rx_q   <= reg_wdata[`SSP_RC_SINGLE];
            cont_rx_q     <= reg_wdata[`SSP_RC_CONT];
         end else if (rx_last) begin
            single_rx_q   <= 1'b0;
         end
         if (reg_wr && reg_addr == `SSP_REG_TX_CTRL) begin
            clk_master_q <= reg_wdata[`SSP_TC_CLK_MASTER];
            nine_tx_q    <= reg_wdata[`SSP_TC_NINE_BIT];
            tx_enable_q  <= reg_wdata[`SSP_TC_TX_EN];
            sync_mode_q  <= reg_wdata[`SSP_TC_SYNC];
            tx_ninth_q   <= reg_wdata[`SSP_TC_NINTH];
         end
         if (reg_wr && reg_addr == `SSP_REG_RATE_CTRL)
            rate_ctrl_q <= reg_wdata;
         if (reg_wr && reg_addr == `SSP_REG_DIV_HI)
            div_hi_q <= reg_wdata;
         if (reg_wr && reg_addr == `SSP_REG_DIV_LO)
            div_lo_q <= reg_wdata;
         if (reg_wr && reg_addr == `SSP_REG_IRQ_CTRL) begin
            rx_ie_q     <= reg_wdata[`SSP_IC_RX_IE];
            tx_ie_q     <= reg_wdata[`SSP_IC_TX_IE];
            periph_ie_q <= reg_wdata[`SSP_IC_PERIPH_IE];
            global_ie_q <= reg_wdata[`SSP_IC_GLOBAL_IE];
            sleep_q     <= reg_wdata[`SSP_IC_SLEEP];
         end else if (wake_q) begin
            sleep_q <= 1'b0;
         end
      end
   end

   // Receive shifter: one bit per trailing edge
   // Bits enter at the top and move down, so after the last sample
   // the character sits right aligned in rx_word
   // The count restarts whenever both receive enables are clear, so a
   // partial character never leaks into the next one
   always @(posedge ref_clk) begin
      if (rst) begin
         rx_shift_q <= 9'h000;
         rx_cnt_q   <= 4'h0;
      end else if (clk_en) begin
         if (!port_enable_q || !rx_mode || !new_cont && !single_rx_q) begin
            rx_cnt_q <= 4'h0;
         end else if (rx_last) begin
            rx_cnt_q <= 4'h0;
         end else if (rx_sample) begin
            rx_shift_q <= {data_sync_q ^ data_inv, rx_shift_q[8:1]};
            rx_cnt_q   <= rx_cnt_q + 4'h1;
         end
      end
   end

   // Two-entry receive buffer with overrun
   // Tail slot is head plus level, taken before any pop of this cycle
   // A pop frees the head slot, so a full buffer that is read and
   // written in one cycle refills the slot that was just read
   // Overrun set has priority over the read and continuous-receive clears in the same cycle; port disable wins over it
   // Port disable flushes the buffer and drops the overrun state
   always @(posedge ref_clk) begin
      if (rst) begin
         rx_head_q      <= 1'b0;
         rx_level_q     <= 2'd0;
         overrun_q      <= 1'b0;
         overrun_cont_q <= 1'b0;
         rx_buf_q[0]    <= 9'h000;
         rx_buf_q[1]    <= 9'h000;
      end else if (clk_en) begin
         if (!new_enable) begin
            rx_head_q  <= 1'b0;
            rx_level_q <= 2'd0;
            overrun_q  <= 1'b0;
         end else begin
            if (buf_push)
               rx_buf_q[rx_head_q ^ rx_level_q[0]] <= rx_word;
            if (buf_pop)
               rx_head_q <= ~rx_head_q;
            rx_level_q <= rx_level_q + {1'b0, buf_push} - {1'b0, buf_pop};
            if (buf_ovf) begin
               overrun_q      <= 1'b1;
               overrun_cont_q <= cont_rx_q;
            end else if (overrun_q && overrun_cont_q && !new_cont) begin
               overrun_q <= 1'b0;
            end else if (overrun_q && !overrun_cont_q && rd_data) begin
               overrun_q <= 1'b0;
            end
         end
      end
   end

   // Transmit holding register and shifter
   // The holding register moves to the shifter when the shifter is idle
   // or in the very cycle its last bit ends, so a second character
   // written during sleep waits there and empty stays low meanwhile
   // A write in the same cycle defers the move by one cycle
   always @(posedge ref_clk) begin
      if (rst) begin
         tx_hold_q      <= 9'h000;
         tx_hold_full_q <= 1'b0;
         tx_shift_q     <= 9'h000;
         tx_cnt_q       <= 4'h0;
         tx_busy_q      <= 1'b0;
      end else if (clk_en) begin
         if (!port_enable_q || !tx_enable_q) begin
            tx_hold_full_q <= 1'b0;
            tx_busy_q      <= 1'b0;
            tx_cnt_q       <= 4'h0;
         end else begin
            if (wr_tx_hold) begin
               tx_hold_q      <= {tx_ninth_q, reg_wdata};
               tx_hold_full_q <= 1'b1;
            end
            if ((!tx_busy_q || tx_done) && tx_hold_full_q && !wr_tx_hold) begin
               tx_shift_q     <= tx_hold_q;
               tx_hold_full_q <= 1'b0;
               tx_busy_q      <= 1'b1;
               tx_cnt_q       <= 4'h0;
            end else if (tx_done) begin
               tx_busy_q <= 1'b0;
               tx_cnt_q  <= 4'h0;
            end else if (tx_active && trail_edge && tx_busy_q) begin
               tx_shift_q <= {1'b0, tx_shift_q[8:1]};
               tx_cnt_q   <= tx_cnt_q + 4'h1;
            end
         end
      end
   end

   // Pin drivers: clock pin never driven in slave mode, data driven in transmit
   always @(posedge ref_clk) begin
      if (rst) begin
         serial_clock_pin_out  <= 1'b0;
         serial_clock_pin_oe_n <= 1'b1;
         serial_data_pin_out   <= 1'b0;
         serial_data_pin_oe_n  <= 1'b1;
      end else if (clk_en) begin
         serial_clock_pin_out  <= 1'b0;
         serial_clock_pin_oe_n <= 1'b1;
         serial_data_pin_oe_n  <= ~(tx_active & tx_busy_q);
         if (!tx_busy_q || lead_edge)
            serial_data_pin_out <= tx_shift_q[0] ^ data_inv;
      end
   end

   // Interrupt and wake outputs
   // Both are levels; the interrupt drops when software removes its cause
   // Wake needs the sleep bit, which then clears itself
   always @(posedge ref_clk) begin
      if (rst) begin
         irq_q  <= 1'b0;
         wake_q <= 1'b0;
      end else if (clk_en) begin
         wake_q <= periph_ie_q & ((tx_ie_q & tx_empty & tx_enable_q)
                   | (rx_ie_q & (rx_level_q != 2'd0))) & sleep_q;
         irq_q  <= global_ie_q & periph_ie_q & ((tx_ie_q & tx_empty & tx_enable_q)
                   | (rx_ie_q & (rx_level_q != 2'd0)));
      end
   end

   // Register read data, one cycle after the strobe
   // Read data is zero in every other cycle
   // Ninth bit comes from the oldest unread entry, so it must be read
   // before the data port read advances the buffer
   always @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= `SSP_RST_BYTE;
      end else if (clk_en) begin
         reg_rdata <= `SSP_RST_BYTE;
         if (reg_rd) begin
            case (reg_addr)
               `SSP_REG_RX_CTRL:   reg_rdata <= {port_enable_q, nine_rx_q, single_rx_q,
                                       cont_rx_q, 2'b00, overrun_q,
                                       rx_buf_q[rx_head_q][8]};
               `SSP_REG_RX_DATA:   reg_rdata <= rx_buf_q[rx_head_q][7:0];
               `SSP_REG_TX_CTRL:   reg_rdata <= {clk_master_q, nine_tx_q, tx_enable_q,
                                       sync_mode_q, 2'b00, ~tx_busy_q, tx_ninth_q};
               `SSP_REG_RATE_CTRL: reg_rdata <= rate_ctrl_q;
               `SSP_REG_DIV_HI:    reg_rdata <= div_hi_q;
               `SSP_REG_DIV_LO:    reg_rdata <= div_lo_q;
               `SSP_REG_IRQ_CTRL:  reg_rdata <= {1'b0, sleep_q, global_ie_q, periph_ie_q,
                                       tx_ie_q, rx_ie_q, tx_empty,
                                       rx_level_q != 2'd0};
               default:            reg_rdata <= `SSP_RST_BYTE;
            endcase
         end
      end
   end
endmodule

// ==== test/ssp_chk.sv ====
// Assertions on the serial port's pins, register port and events
`timescale 1ns/1ps
`include "ssp_defs.vh"
module ssp_chk (
   // Clock and control
   input wire       ref_clk,
   input wire       rst,
   input wire       clk_en,
   // Register port
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   // Pins and events
   input wire       serial_clock_pin_in,
   input wire       serial_clock_pin_out,
   input wire       serial_clock_pin_oe_n,
   input wire       serial_data_pin_in,
   input wire       serial_data_pin_out,
   input wire       serial_data_pin_oe_n,
   input wire       irq_q,
   input wire       wake_q
);
   reg       cont_q, port_q, transmit_enable_q, glob_q, ckp_q;
   reg [3:0] lead_q;
   // Written enables and cycles since the last clock rise
   always @(posedge ref_clk) begin
      if (rst) begin
         {cont_q, port_q, transmit_enable_q, glob_q, ckp_q} <= 5'h00;
         lead_q <= 4'hf;
      end else if (clk_en) begin
         ckp_q <= serial_clock_pin_in;
         if (serial_clock_pin_in && !ckp_q)
            lead_q <= 4'h0;
         else if (lead_q != 4'hf)
            lead_q <= lead_q + 4'h1;
         if (reg_wr && reg_addr == `SSP_REG_RX_CTRL)
            {port_q, cont_q} <= {reg_wdata[7], reg_wdata[4]};
         if (reg_wr && reg_addr == `SSP_REG_TX_CTRL)
            transmit_enable_q <= reg_wdata[5];
         if (reg_wr && reg_addr == `SSP_REG_IRQ_CTRL)
            glob_q <= reg_wdata[5];
      end
   end
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Clock pin only ever an input
   property p_ck_in; serial_clock_pin_oe_n && !serial_clock_pin_out; endproperty
   a_ck_in: assert property (p_ck_in) else $error("clock pin driven");
   // Read data only in the cycle after a read
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_wo; reg_rd && reg_addr == `SSP_REG_TX_HOLD |=> reg_rdata == 8'h00; endproperty
   a_wo: assert property (p_wo) else $error("holding register readable");
   // Data line released unless transmitting
   property p_rx_rel; cont_q && $past(cont_q) |-> serial_data_pin_oe_n; endproperty
   a_rx_rel: assert property (p_rx_rel) else $error("data driven in receive");
   property p_tx_en; !transmit_enable_q && !$past(transmit_enable_q) |-> serial_data_pin_oe_n; endproperty
   a_tx_en: assert property (p_tx_en) else $error("data driven without enable");
   property p_port; !port_q && !$past(port_q) |-> serial_data_pin_oe_n; endproperty
   a_port: assert property (p_port) else $error("data driven while off");
   // Interrupt needs the global enable
   property p_glob; !glob_q && !$past(glob_q) |-> !irq_q; endproperty
   a_glob: assert property (p_glob) else $error("irq without global enable");
   // Driven data changes only shortly after a leading edge
   property p_lead; !serial_data_pin_oe_n && !$past(serial_data_pin_oe_n)
      && $changed(serial_data_pin_out) |-> lead_q <= 4'h5; endproperty
   a_lead: assert property (p_lead) else $error("data changed off leading edge");
endmodule
bind ssp_sync_slave ssp_chk ssp_chk_i (.ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe_n,
   .serial_data_pin_in, .serial_data_pin_out, .serial_data_pin_oe_n, .irq_q, .wake_q);

// ==== test/ssp_mstr.sv ====
// Far-side synchronous master: makes the clock and exchanges characters
`timescale 1ns/1ps
module ssp_mstr (
   // Link outputs
   output reg  sclk,
   output reg  sdata,
   // Resolved data line
   input  wire line
);
   // Clock idles low between frames
   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
   end
   // One character LSB first at a given half period
   task xfer(input [8:0] tx, input integer n, input integer h, output [8:0] rx);
      integer i;
      begin
         rx = 9'h000;
         for (i = 0; i < n; i = i + 1) begin
            sclk = 1'b1;
            sdata = tx[i];
            #(h);
            sclk = 1'b0;
            rx[i] = line;
            #(h);
         end
         sdata = ~sdata; // Released line shows no stale bit
      end
   endtask
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the synchronous slave serial port
`timescale 1ns/1ps
module tb_top;
   reg        ref_clk, rst, clk_en, reg_wr, reg_rd;
   reg  [2:0] reg_addr;
   reg  [7:0] reg_wdata;
   reg  [8:0] rx;
   wire [7:0] reg_rdata;
   wire       sclk, sdata, serial_clock_pin_out, serial_clock_pin_oe_n;
   wire       serial_data_pin_out, serial_data_pin_oe_n, irq_q, wake_q;
   integer    error_cnt, tests_run, i;
   // Pin levels from the slave's enables over the master's drive
   wire       serial_clock_pin_in = serial_clock_pin_oe_n ? sclk : serial_clock_pin_out;
   wire       serial_data_pin_in = serial_data_pin_oe_n ? sdata : serial_data_pin_out;
   // Design and far-side master
   ssp_sync_slave ssp_sync_slave_i (.ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe_n,
      .serial_data_pin_in, .serial_data_pin_out, .serial_data_pin_oe_n, .irq_q, .wake_q);
   ssp_mstr ssp_mstr_i (.sclk, .sdata, .line(serial_data_pin_in));
   // Compare and count
   task chk(input [8:0] got, input [8:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // One-cycle register write
   task wr(input [2:0] a, input [7:0] d);
      begin
         @(posedge ref_clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
      end
   endtask
   // One-cycle read, masked data taken in the next cycle
   task rchk(input [2:0] a, input [7:0] m, input [7:0] e);
      begin
         @(posedge ref_clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         #1;
         chk({1'b0, reg_rdata & m}, {1'b0, e});
      end
   endtask
   // One character over the link, then settle
   task send(input [8:0] d, input integer n, input integer h);
      begin
         #7;
         ssp_mstr_i.xfer(d, n, h, rx);
         repeat (8) @(posedge ref_clk);
      end
   endtask
   // Counts and verdict
   task print_verdict;
      begin
         $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
         if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // System clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // Hang guard
   initial begin
      #500_000;
      error_cnt = error_cnt + 1;
      print_verdict;
   end
   // Main sequence
   initial begin
      error_cnt = 0;
      tests_run = 0;
      rst = 1'b1;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
         if (i != 1)
            rchk(i[2:0], (i == 2) ? 8'hfd : 8'hff, (i == 7) ? 8'h02 : 8'h00);
      for (i = 3; i < 6; i = i + 1) begin
         wr(i[2:0], {5'h00, i[2:0]});
         rchk(i[2:0], 8'hff, {5'h00, i[2:0]});
      end
      // Continuous slave receive into overrun
      wr(3'h2, 8'h10);
      wr(3'h0, 8'h90);
      send(9'h0a5, 8, 200);
      rchk(3'h7, 8'h01, 8'h01);
      send(9'h03c, 8, 200);
      send(9'h07e, 8, 200);
      rchk(3'h0, 8'h02, 8'h02);
      send(9'h011, 8, 200);
      rchk(3'h1, 8'hff, 8'ha5);
      rchk(3'h7, 8'h01, 8'h01);
      rchk(3'h1, 8'hff, 8'h3c);
      rchk(3'h7, 8'h01, 8'h00);
      rchk(3'h0, 8'h02, 8'h02);
      wr(3'h0, 8'h80);
      rchk(3'h0, 8'h02, 8'h00);
      // Nine-bit characters
      wr(3'h0, 8'hd0);
      send(9'h15a, 9, 200);
      send(9'h0c3, 9, 200);
      rchk(3'h0, 8'h01, 8'h01);
      rchk(3'h1, 8'hff, 8'h5a);
      rchk(3'h0, 8'h01, 8'h00);
      rchk(3'h1, 8'hff, 8'hc3);
      // Single receive into overrun
      for (i = 0; i < 3; i = i + 1) begin
         wr(3'h0, 8'ha0);
         send({1'b0, 8'h40 + i[7:0]}, 8, 200);
         rchk(3'h0, 8'h20, 8'h00);
      end
      rchk(3'h0, 8'h02, 8'h02);
      rchk(3'h1, 8'hff, 8'h40);
      rchk(3'h0, 8'h02, 8'h00);
      rchk(3'h1, 8'hff, 8'h41);
      // Port disable flushes
      wr(3'h0, 8'h90);
      send(9'h055, 8, 200);
      wr(3'h0, 8'h00);
      rchk(3'h7, 8'h01, 8'h00);
      // Slave transmit of two characters in sleep
      wr(3'h0, 8'h80);
      wr(3'h2, 8'h30);
      wr(3'h6, 8'h96);
      wr(3'h6, 8'h3b);
      wr(3'h7, 8'h58);
      rchk(3'h7, 8'h02, 8'h00);
      chk({8'h00, wake_q}, 9'h000);
      send(9'h000, 8, 200);
      chk(rx, 9'h096);
      rchk(3'h7, 8'h42, 8'h02);
      wr(3'h7, 8'h38);
      repeat (3) @(posedge ref_clk);
      chk({8'h00, irq_q}, 9'h001);
      send(9'h000, 8, 200);
      chk(rx, 9'h03b);
      print_verdict;
   end
endmodule
